/* File: hw/ochp_pkg.sv */
// shared constants and types of the overcurrent, hiccup and thermal protection block
package ochp_pkg;
  // clock and blanking time
  localparam int CLK_PERIOD_PS = 25000;
  localparam int BLANK_TIME_NS = 70;
  // least time, so round up to whole cycles
  localparam int BLANK_CYCLES = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] BLANK_CNT_LOAD = 4'(BLANK_CYCLES);
  localparam logic [3:0] BLANK_CNT_RST = 4'h0;
  // timer dump length after hiccup ends
  localparam int DUMP_CYCLES = 4;
  // dead time between primary fall and rectifier rise
  localparam int DEAD_CYCLES = 6;
  // synchroniser bit positions of the analog flags
  localparam int SY_LIMIT = 0;
  localparam int SY_PWM = 1;
  localparam int SY_TMR_HI = 2;
  localparam int SY_TMR_LO = 3;
  localparam int SY_HOT = 4;
  localparam int SY_SS_DONE = 5;
  localparam int SY_WIDTH = 6;
  // protection states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HICCUP = 4'h2,
    ST_DUMP = 4'h4,
    ST_THERMAL = 4'h8
  } ochp_state_t;
  localparam ochp_state_t STATE_RST = ST_RUN;
endpackage

/* File: hw/ochp_blank_if.sv */
// carrier between the pulse control and the leading edge blanker
`timescale 1ns/1ps
interface ochp_blank_if;
  logic start;
  logic blank;
  modport ctl (output start, input blank);
  modport blk (input start, output blank);
endinterface

/* File: hw/ochp_sync.sv */
// three stage synchroniser bank with agreement filter
`timescale 1ns/1ps
module ochp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // asynchronous flags in, filtered flags out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q, agree;

  // a bit only moves once stages two and three agree
  always_comb begin
    agree = ~(s2_ff ^ s3_ff);
    nxt_q = (agree & s3_ff) | (~agree & q_ff);
  end

  // stage one feeds stage two only
  always_ff @(posedge clock) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff;
endmodule

/* File: hw/ochp_blank.sv */
// leading edge blanker that pulls the current sense input low
`timescale 1ns/1ps
module ochp_blank
  import ochp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // start strobe in, blank level out
  ochp_blank_if.blk bif
);
  logic [3:0] cnt_ff, nxt_cnt;
  logic blank_ff, nxt_blank;

  // high from the cycle edge until the count after the drive rise runs out
  always_comb begin
    nxt_cnt = cnt_ff;
    if (bif.start) begin
      nxt_cnt = BLANK_CNT_LOAD;
    end else if (cnt_ff != 4'h0) begin
      nxt_cnt = cnt_ff - 4'h1;
    end
    nxt_blank = bif.start | (cnt_ff > 4'h1);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_ff <= BLANK_CNT_RST;
      blank_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      blank_ff <= nxt_blank;
    end
  end

  assign bif.blank = blank_ff;
endmodule

/* File: hw/ochp_protect.sv */
// primary pulse control with current limit, hiccup restart and thermal shutdown
//
// Function
// - current sense above limit ends the active primary pulse in that cycle, unless it is a matched pulse.
// - during persisting overcurrent, pulse width comes from the limit trip.
// - sense input held low at each cycle start and 70 ns after drive rise.
// - a pulse cut by limit gives the other switch an equal width next.
// - any limit trip charges the overcurrent timer with the source.
// - limit gone before upper threshold: stop charging, discharge with the sink.
// - timer at upper threshold shuts all four drives and enters hiccup.
// - in hiccup drives low, soft-start grounded, sink until lower threshold.
// - at lower threshold the timer is fully dumped for the next event.
// - leaving hiccup restarts through a complete soft-start.
// - over-temperature enters standby with all four drives off.
// - stay off until hot flag clears, then a normal start-up.
// - after soft-start done, rectifier duty is primary complement less dead time.
`timescale 1ns/1ps
module ochp_protect
  import ochp_pkg::*;
#(
  parameter int WIDTH_BITS = 8,
  parameter int MAX_WIDTH = 200
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // switching cycle timing from the oscillator, same clock
  input wire logic half_cycle_start,
  input wire logic half_cycle_b,
  // soft-start driven rectifier requests, same clock
  input wire logic sr_a_req,
  input wire logic sr_b_req,
  // analog comparator flags, asynchronous
  input wire logic current_limit_trip,
  input wire logic pwm_trip,
  input wire logic timer_at_upper,
  input wire logic timer_at_lower,
  input wire logic over_temp,
  input wire logic soft_start_done,
  // drive outputs
  output logic primary_drive_a,
  output logic primary_drive_b,
  output logic rectifier_drive_a,
  output logic rectifier_drive_b,
  // analog control outputs
  output logic current_sense_limit_input_pulldown,
  output logic timer_charge,
  output logic timer_sink,
  output logic timer_dump,
  output logic soft_start_clamp
);
  localparam logic [WIDTH_BITS-1:0] W_MAX = WIDTH_BITS'(MAX_WIDTH);
  localparam logic [WIDTH_BITS-1:0] W_ONE = WIDTH_BITS'(1);
  localparam logic [2:0] DUMP_LAST = 3'(DUMP_CYCLES - 1);
  localparam logic [3:0] DEAD_DONE = 4'(DEAD_CYCLES);

  logic [SY_WIDTH-1:0] sy;
  logic sy_limit, sy_pwm, sy_hi, sy_lo, sy_hot, sy_ss;
  logic run, start, limit_hit;

  ochp_state_t state_ff, nxt_state;
  logic pulse_ff, nxt_pulse;
  logic phase_ff, nxt_phase;
  logic [WIDTH_BITS-1:0] width_ff, nxt_width;
  logic match_ff, nxt_match;
  logic [WIDTH_BITS-1:0] match_w_ff, nxt_match_w;
  logic oc_seen_ff, nxt_oc_seen;
  logic [2:0] dump_cnt_ff, nxt_dump_cnt;
  logic [3:0] dead_cnt_ff, nxt_dead_cnt;
  logic pa_ff, pb_ff, ra_ff, rb_ff;
  logic nxt_pa, nxt_pb, nxt_ra, nxt_rb;
  logic chg_ff, sink_ff, dump_ff, clamp_ff;
  logic nxt_chg, nxt_sink, nxt_dump, nxt_clamp;

  ochp_blank_if bif ();

  // every comparator flag crosses in through the filter bank
  ochp_sync #(
    .W(SY_WIDTH)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({soft_start_done, over_temp, timer_at_lower, timer_at_upper,
               pwm_trip, current_limit_trip}),
    .sync_out(sy)
  );

  ochp_blank u_blank (
    .clock(clock),
    .reset(reset),
    .bif(bif.blk)
  );

  assign sy_limit = sy[SY_LIMIT];
  assign sy_pwm = sy[SY_PWM];
  assign sy_hi = sy[SY_TMR_HI];
  assign sy_lo = sy[SY_TMR_LO];
  assign sy_hot = sy[SY_HOT];
  assign sy_ss = sy[SY_SS_DONE];

  // pulldown at every half cycle edge, even when not running
  assign bif.start = half_cycle_start;
  assign run = (state_ff == ST_RUN);
  assign start = half_cycle_start & run;
  // a trip under the blanking window is leading edge noise
  assign limit_hit = sy_limit & ~bif.blank;

  // protection state machine; thermal is checked first so it always wins
  always_comb begin
    nxt_state = state_ff;
    nxt_dump_cnt = dump_cnt_ff;
    if (sy_hot) begin
      nxt_state = ST_THERMAL;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (sy_hi) begin
            nxt_state = ST_HICCUP;
          end
        end
        ST_HICCUP: begin
          if (sy_lo) begin
            nxt_state = ST_DUMP;
            nxt_dump_cnt = 3'h0;
          end
        end
        ST_DUMP: begin
          nxt_dump_cnt = dump_cnt_ff + 3'h1;
          if (dump_cnt_ff == DUMP_LAST) begin
            nxt_state = ST_RUN;
          end
        end
        ST_THERMAL: begin
          nxt_state = ST_RUN;
        end
        default: begin
          nxt_state = ST_THERMAL;
        end
      endcase
    end
  end

  // primary pulse width control with duty matching
  always_comb begin
    nxt_pulse = pulse_ff;
    nxt_phase = phase_ff;
    nxt_width = width_ff;
    nxt_match = match_ff;
    nxt_match_w = match_w_ff;
    if (!run || nxt_state != ST_RUN) begin
      nxt_pulse = 1'b0;
      nxt_match = 1'b0;
    end else if (start) begin
      nxt_pulse = 1'b1;
      nxt_phase = half_cycle_b;
      nxt_width = W_ONE;
    end else if (pulse_ff) begin
      nxt_width = width_ff + W_ONE;
      if (match_ff) begin
        // matched pulse ignores the sense and pwm comparators
        if (width_ff >= match_w_ff) begin
          nxt_pulse = 1'b0;
          nxt_match = 1'b0;
        end
      end else if (limit_hit) begin
        // width set by the limit trip, remembered for the other switch
        nxt_pulse = 1'b0;
        nxt_match = 1'b1;
        nxt_match_w = width_ff;
      end else if (sy_pwm || width_ff >= W_MAX) begin
        nxt_pulse = 1'b0;
      end
    end
    nxt_pa = nxt_pulse & ~nxt_phase;
    nxt_pb = nxt_pulse & nxt_phase;
  end

  // rectifier drive, soft-start requests first, complement once done
  always_comb begin
    nxt_dead_cnt = dead_cnt_ff;
    if (nxt_pulse) begin
      nxt_dead_cnt = 4'h0;
    end else if (dead_cnt_ff != DEAD_DONE) begin
      nxt_dead_cnt = dead_cnt_ff + 4'h1;
    end
    nxt_ra = 1'b0;
    nxt_rb = 1'b0;
    if (nxt_state == ST_RUN && run && !nxt_pulse) begin
      if (sy_ss) begin
        nxt_ra = (dead_cnt_ff == DEAD_DONE);
        nxt_rb = (dead_cnt_ff == DEAD_DONE);
      end else begin
        nxt_ra = sr_a_req;
        nxt_rb = sr_b_req;
      end
    end
  end

  // overcurrent timer and soft-start control
  always_comb begin
    nxt_oc_seen = oc_seen_ff;
    if (!run) begin
      nxt_oc_seen = 1'b0;
    end else if (limit_hit) begin
      nxt_oc_seen = 1'b1;
    end else if (start) begin
      // each half cycle start ends the limit condition unless a trip falls in that same cycle
      nxt_oc_seen = 1'b0;
    end
    nxt_chg = (nxt_state == ST_RUN) & run & nxt_oc_seen;
    nxt_sink = (nxt_state == ST_HICCUP) | ((nxt_state == ST_RUN) & ~nxt_chg);
    nxt_dump = (nxt_state == ST_DUMP) | (nxt_state == ST_THERMAL);
    // held low until the run state returns, so the ramp starts from ground
    nxt_clamp = (nxt_state != ST_RUN);
  end

  // register every state and output
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= STATE_RST;
      dump_cnt_ff <= 3'h0;
      pulse_ff <= 1'b0;
      phase_ff <= 1'b0;
      width_ff <= '0;
      match_ff <= 1'b0;
      match_w_ff <= '0;
      oc_seen_ff <= 1'b0;
      dead_cnt_ff <= 4'h0;
      pa_ff <= 1'b0;
      pb_ff <= 1'b0;
      ra_ff <= 1'b0;
      rb_ff <= 1'b0;
      chg_ff <= 1'b0;
      sink_ff <= 1'b0;
      dump_ff <= 1'b1;
      clamp_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      dump_cnt_ff <= nxt_dump_cnt;
      pulse_ff <= nxt_pulse;
      phase_ff <= nxt_phase;
      width_ff <= nxt_width;
      match_ff <= nxt_match;
      match_w_ff <= nxt_match_w;
      oc_seen_ff <= nxt_oc_seen;
      dead_cnt_ff <= nxt_dead_cnt;
      pa_ff <= nxt_pa;
      pb_ff <= nxt_pb;
      ra_ff <= nxt_ra;
      rb_ff <= nxt_rb;
      chg_ff <= nxt_chg;
      sink_ff <= nxt_sink;
      dump_ff <= nxt_dump;
      clamp_ff <= nxt_clamp;
    end
  end

  assign primary_drive_a = pa_ff;
  assign primary_drive_b = pb_ff;
  assign rectifier_drive_a = ra_ff;
  assign rectifier_drive_b = rb_ff;
  assign current_sense_limit_input_pulldown = bif.blank;
  assign timer_charge = chg_ff;
  assign timer_sink = sink_ff;
  assign timer_dump = dump_ff;
  assign soft_start_clamp = clamp_ff;
endmodule

/* File: sim/ochp_power_stage.sv */
// power stage and analog node model facing the protection block
`timescale 1ns/1ps
module ochp_power_stage #(
  parameter int PWM_LEN = 12,
  parameter int LIM_LEN = 2,
  parameter int UP = 60,
  parameter int LO = 10,
  parameter int SS_TOP = 64
) (
  // clock and scenario control
  input wire logic clock,
  input wire logic overload,
  // drives and analog controls from the block
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic sense_pd,
  input wire logic charge,
  input wire logic sink,
  input wire logic dump,
  input wire logic clamp,
  // comparator flags back to the block
  output logic limit_trip,
  output logic pwm_trip,
  output logic at_upper,
  output logic at_lower,
  output logic ss_done
);
  int on_cnt = 0;
  int node = 0;
  int ss = 0;
  // switch current ramps while on; sense stays at zero while pulled down
  always @(posedge clock) begin
    on_cnt <= (drive_a || drive_b) ? on_cnt + 1 : 0;
  end
  assign limit_trip = overload && !sense_pd && on_cnt >= LIM_LEN;
  assign pwm_trip = on_cnt >= PWM_LEN;
  // timer node as a count; dump wins over charge, charge over sink
  always @(posedge clock) begin
    if (dump) begin
      node <= 0;
    end else if (charge) begin
      node <= node + 1;
    end else if (sink && node > 0) begin
      node <= node - 1;
    end
    ss <= clamp ? 0 : (ss < SS_TOP ? ss + 1 : ss);
  end
  assign at_upper = node >= UP;
  assign at_lower = node <= LO;
  assign ss_done = ss >= SS_TOP;
endmodule

/* File: sim/ochp_protect_asserts.sv */
// concurrent checks on the protection block ports
`timescale 1ns/1ps
module ochp_protect_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // flags watched
  input wire logic current_limit_trip,
  input wire logic timer_at_upper,
  input wire logic timer_at_lower,
  input wire logic over_temp,
  // outputs watched
  input wire logic primary_drive_a,
  input wire logic primary_drive_b,
  input wire logic rectifier_drive_a,
  input wire logic rectifier_drive_b,
  input wire logic current_sense_limit_input_pulldown,
  input wire logic timer_charge,
  input wire logic timer_sink,
  input wire logic timer_dump,
  input wire logic soft_start_clamp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // a trip the blanker lets through, outside shutdown
  sequence open_trip;
    (current_limit_trip && !current_sense_limit_input_pulldown && !soft_start_clamp)[*2];
  endsequence
  // upper threshold held with no thermal event
  sequence upper_held;
    (timer_at_upper && !timer_at_lower && !over_temp)[*6];
  endsequence
  sequence dump_run;
    timer_dump[*4] ##1 !timer_dump;
  endsequence
  blank_rise_a: assert property (
    ($rose(primary_drive_a) || $rose(primary_drive_b)) |->
      current_sense_limit_input_pulldown[*3]) else $error("blanking too short");
  trip_charge_a: assert property (open_trip |-> ##[1:7] timer_charge)
    else $error("trip did not charge timer");
  upper_hiccup_a: assert property (upper_held |=> soft_start_clamp && !timer_charge)
    else $error("no hiccup at upper threshold");
  clamp_quiet_a: assert property (
    soft_start_clamp |-> !(primary_drive_a || primary_drive_b || rectifier_drive_a
      || rectifier_drive_b)) else $error("drive active while shut down");
  dump_len_a: assert property ($rose(timer_dump) && !over_temp |-> dump_run)
    else $error("timer dump length wrong");
  hot_standby_a: assert property (over_temp[*6] |=> soft_start_clamp && timer_dump)
    else $error("no standby when hot");
  charge_sink_a: assert property (!(timer_charge && timer_sink))
    else $error("charge and sink together");
  rect_excl_a: assert property (
    (primary_drive_a || primary_drive_b) |-> !(rectifier_drive_a || rectifier_drive_b))
    else $error("rectifier on with primary");
endmodule
bind ochp_protect ochp_protect_asserts u_chk (.*);

/* File: sim/ochp_protect_tb.sv */
// self-checking bench of the protection block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module ochp_protect_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hc_start = 1'b0;
  logic hc_b = 1'b0;
  logic over_temp = 1'b0;
  logic overload = 1'b0;
  logic pa, pb, ra, rb, pd, chg, snk, dmp, clp, lim, pwm, up, lo, ssd;
  int n_mismatch = 0;
  int check_count = 0;
  int w_norm, wa, wb, nd;
  always #12.5 clock = ~clock;
  ochp_protect u_dut (.clock(clock), .reset(reset), .half_cycle_start(hc_start),
    .half_cycle_b(hc_b), .sr_a_req(1'b0), .sr_b_req(1'b0), .current_limit_trip(lim),
    .pwm_trip(pwm), .timer_at_upper(up), .timer_at_lower(lo), .over_temp(over_temp),
    .soft_start_done(ssd), .primary_drive_a(pa), .primary_drive_b(pb),
    .rectifier_drive_a(ra), .rectifier_drive_b(rb),
    .current_sense_limit_input_pulldown(pd), .timer_charge(chg), .timer_sink(snk),
    .timer_dump(dmp), .soft_start_clamp(clp));
  ochp_power_stage u_stage (.clock(clock), .overload(overload), .drive_a(pa),
    .drive_b(pb), .sense_pd(pd), .charge(chg), .sink(snk), .dump(dmp), .clamp(clp),
    .limit_trip(lim), .pwm_trip(pwm), .at_upper(up), .at_lower(lo), .ss_done(ssd));
  // one half cycle on phase b; counts cycles its drive is high
  task automatic hc(input logic b, output int w);
    w = 0;
    hc_start <= 1'b1;
    hc_b <= b;
    @(posedge clock);
    hc_start <= 1'b0;
    repeat (24) begin
      @(negedge clock);
      if ((b ? pb : pa) === 1'b1) w++;
    end
    @(posedge clock);
  endtask
  task automatic t_pulse();
    hc(1'b0, w_norm);
    `CHK("normal width", 1'b1, w_norm > 10 && w_norm < 24)
    `CHK("rect after dead time", 2'b11, {ra, rb})
  endtask
  task automatic t_limit();
    overload <= 1'b1;
    hc(1'b0, wa);
    hc(1'b1, wb);
    `CHK("cut short", 1'b1, wa > 0 && wa < w_norm)
    `CHK("matched width", wa, wb)
    `CHK("charging", 1'b1, chg)
    overload <= 1'b0;
    hc(1'b0, wa);
    hc(1'b1, wa);
    `CHK("sink after clear", 2'b01, {chg, snk})
  endtask
  task automatic t_hiccup();
    overload <= 1'b1;
    for (int i = 0; i < 20 && clp !== 1'b1; i++) hc(i[0], wa);
    overload <= 1'b0;
    `CHK("hiccup clamp", 2'b11, {clp, snk})
    hc(1'b0, wa);
    `CHK("no pulse in hiccup", 0, wa)
    nd = 0;
    for (int i = 0; i < 400 && clp === 1'b1; i++) begin
      @(negedge clock);
      if (dmp === 1'b1) nd++;
    end
    `CHK("dump cycles", 4, nd)
    @(posedge clock);
    `CHK("soft restart rect", 1'b0, ra)
  endtask
  task automatic t_thermal();
    over_temp <= 1'b1;
    repeat (8) @(posedge clock);
    hc(1'b1, wa);
    `CHK("hot standby", 0, wa)
    over_temp <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK("cool restart", 1'b0, clp)
    hc(1'b1, wa);
    `CHK("pulse after cool", 1'b1, wa > 0)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // scenarios in order
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (80) @(posedge clock);
    t_pulse();
    t_limit();
    t_hiccup();
    t_thermal();
    end_of_test();
  end
  // hang guard, well past the expected run of under 2000 cycles
  initial begin
    repeat (6000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
endmodule
